/* File: shared/uart_fifo_pkg.sv */
// constants and types shared by the fifo serial transceiver
// Behaviour
// - serial enable runs transmit and receive
// - stop select gives two or one stops
// - word length code picks 5 to 8 bits
// - break bit holds serial output low
// - parity enable write; read gives head parity error
// - stick parity sends parity bit as one
// - two fifteen byte fifos, separate thresholds
// - sixteen bit baud divisor from system clock
// - fifo status reads rx count high, tx low
// - rx ready when count exceeds rx threshold
// - tx ready when count below tx threshold
// - zero divisor low bits, enable off: fifo reset
// - master enable gates interrupt; ones enable flags
// - tx ready follows its condition
// - rx ready on idle timeout with bytes left below rx threshold
// - rx ready clears only below threshold on zero write
// - rx overflow on byte into full fifo
// - rx underflow on read of empty fifo
// - tx overflow on write into full fifo
// - framing error on bad stop bit
// - tx done once all bytes shifted out
// - data read pops rx, write pushes tx
// - bit rate is clock over divisor
package uart_fifo_pkg;
  localparam logic [7:0] FIFO_LEVEL_THRESHOLD_ADDR = 8'ha5;
  localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'ha6;
  localparam logic [7:0] IRQ_FLAG_ENABLE_ADDR = 8'ha7;
  localparam logic [7:0] SERIAL_LINE_CONFIG_ADDR = 8'hc2;
  localparam logic [7:0] BAUD_DIVISOR_HIGH_ADDR = 8'ha3;
  localparam logic [7:0] BAUD_DIVISOR_LOW_ADDR = 8'ha4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 15;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'hf;
  localparam int IDLE_BITS_PER_STEP = 16;
  localparam int FLAG_TX_DONE = 0;
  localparam int FLAG_FRAMING = 1;
  localparam int FLAG_TX_OVF = 2;
  localparam int FLAG_RX_UNF = 3;
  localparam int FLAG_RX_OVF = 4;
  localparam int FLAG_RX_AVAIL = 5;
  localparam int FLAG_TX_READY = 6;
  localparam int IRQ_MASTER_BIT = 7;
  typedef struct packed {
    logic serial_enable;
    logic two_stop_select;
    logic [1:0] word_length_select;
    logic break_ctrl;
    logic odd_parity_select;
    logic parity_enable;
    logic stick_parity_one;
  } line_cfg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage

/* File: verilog/uart_fifo_core.sv */
// fifo serial transceiver with register port and baud divisor
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_core (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // serial line and interrupt
  input wire logic I_RXD,
  output logic O_TXD,
  output logic O_IRQ
);
  uart_fifo_pkg::reg_req_t req;
  uart_fifo_pkg::line_cfg_t cfg_q;
  logic [15:0] baud_q;
  logic [3:0] rx_thr_q, tx_thr_q;
  logic [6:0] irq_en_q;
  logic irq_master_q;
  logic [6:0] flag_q;
  logic [7:0] rdata_q;
  logic txd_q, irq_q;
  logic [7:0] tx_mem_q [0:14];
  logic [8:0] rx_mem_q [0:14];
  logic [3:0] tx_cnt_q, tx_rd_q, tx_wr_q;
  logic [3:0] rx_cnt_q, rx_rd_q, rx_wr_q;
  logic [15:0] tx_div_q, rx_div_q;
  logic tx_tick, rx_tick, rx_half;
  uart_fifo_pkg::tx_state_t tx_st_q;
  uart_fifo_pkg::rx_state_t rx_st_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  logic tx_par_q, rx_par_q, tx_stop2_q, rx_parity_error_flag_q;
  logic [23:0] idle_q;
  logic fifo_rst, wr_data, rd_data, tx_pop, rx_push, rx_framing_error_flag, tx_busy;
  logic [3:0] nbits;
  logic [23:0] idle_lim;

  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign nbits = {2'b00, cfg_q.word_length_select} + 4'h5;
  assign wr_data = I_CE && req.wr && req.addr == uart_fifo_pkg::SERIAL_DATA_BUFFER_ADDR;
  assign rd_data = I_CE && req.rd && req.addr == uart_fifo_pkg::SERIAL_DATA_BUFFER_ADDR;
  // fifo reset takes effect when the divisor low bits and enable are both zero
  assign fifo_rst = baud_q[11:0] == 12'h000 && !cfg_q.serial_enable;
  assign tx_pop = I_CE && cfg_q.serial_enable && tx_st_q == uart_fifo_pkg::TX_IDLE &&
                  tx_cnt_q != 4'h0 && !cfg_q.break_ctrl;
  assign tx_busy = tx_st_q != uart_fifo_pkg::TX_IDLE;
  // 15 * 16 * 65535 needs 24 bits; a narrower product would wrap on slow rates
  assign idle_lim = 24'(rx_thr_q) * 24'(uart_fifo_pkg::IDLE_BITS_PER_STEP) * 24'(baud_q);

  function automatic logic parity_of(input logic [7:0] d, input logic [3:0] n,
                                     input uart_fifo_pkg::line_cfg_t c);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    if (c.stick_parity_one) begin
      return 1'b1;
    end
    return p ^ c.odd_parity_select;
  endfunction

  // configuration registers
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg_q <= uart_fifo_pkg::REG_RESET;
      baud_q <= uart_fifo_pkg::BAUD_RESET;
      rx_thr_q <= 4'h0;
      tx_thr_q <= 4'h0;
      irq_en_q <= 7'h00;
      irq_master_q <= 1'b0;
    end else if (I_CE && req.wr) begin
      if (req.addr == uart_fifo_pkg::SERIAL_LINE_CONFIG_ADDR) begin
        cfg_q <= req.wdata;
      end else if (req.addr == uart_fifo_pkg::FIFO_LEVEL_THRESHOLD_ADDR) begin
        rx_thr_q <= req.wdata[7:4];
        tx_thr_q <= req.wdata[3:0];
      end else if (req.addr == uart_fifo_pkg::IRQ_FLAG_ENABLE_ADDR) begin
        irq_master_q <= req.wdata[uart_fifo_pkg::IRQ_MASTER_BIT];
        irq_en_q <= req.wdata[6:0];
      end else if (req.addr == uart_fifo_pkg::BAUD_DIVISOR_HIGH_ADDR) begin
        baud_q[15:8] <= req.wdata;
      end else if (req.addr == uart_fifo_pkg::BAUD_DIVISOR_LOW_ADDR) begin
        baud_q[7:0] <= req.wdata;
      end
    end
  end

  // baud tick generators; a zero divisor stops both
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_div_q <= 16'h0000;
      rx_div_q <= 16'h0000;
    end else if (I_CE) begin
      tx_div_q <= (tx_tick || tx_pop) ? 16'h0000 : tx_div_q + 16'h0001;
      if (rx_st_q == uart_fifo_pkg::RX_IDLE || rx_tick) begin
        rx_div_q <= 16'h0000;
      end else begin
        rx_div_q <= rx_div_q + 16'h0001;
      end
    end
  end
  assign tx_tick = baud_q != 16'h0000 && tx_div_q >= baud_q - 16'h0001;
  assign rx_tick = baud_q != 16'h0000 && rx_div_q >= baud_q - 16'h0001;
  assign rx_half = rx_div_q == {1'b0, baud_q[15:1]};

  // transmit and receive fifo storage, indexed by write pointers
  always_ff @(posedge I_CLK) begin
    if (I_CE && wr_data && tx_cnt_q != uart_fifo_pkg::FIFO_FULL_COUNT) begin
      tx_mem_q[tx_wr_q] <= req.wdata;
    end
    if (rx_push && rx_cnt_q != uart_fifo_pkg::FIFO_FULL_COUNT) begin
      rx_mem_q[rx_wr_q] <= {rx_parity_error_flag_q && cfg_q.parity_enable, rx_sh_q};
    end
  end

  // fifo pointers and counts
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_cnt_q <= 4'h0;
      tx_rd_q <= 4'h0;
      tx_wr_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_rd_q <= 4'h0;
      rx_wr_q <= 4'h0;
    end else if (I_CE) begin
      if (fifo_rst) begin
        tx_cnt_q <= 4'h0;
        tx_rd_q <= 4'h0;
        tx_wr_q <= 4'h0;
        rx_cnt_q <= 4'h0;
        rx_rd_q <= 4'h0;
        rx_wr_q <= 4'h0;
      end else begin
        if (wr_data && tx_cnt_q != uart_fifo_pkg::FIFO_FULL_COUNT) begin
          tx_wr_q <= tx_wr_q == 4'he ? 4'h0 : tx_wr_q + 4'h1;
        end
        if (tx_pop) begin
          tx_rd_q <= tx_rd_q == 4'he ? 4'h0 : tx_rd_q + 4'h1;
        end
        tx_cnt_q <= tx_cnt_q + 4'((wr_data && tx_cnt_q != uart_fifo_pkg::FIFO_FULL_COUNT))
                    - 4'(tx_pop);
        if (rx_push && rx_cnt_q != uart_fifo_pkg::FIFO_FULL_COUNT) begin
          rx_wr_q <= rx_wr_q == 4'he ? 4'h0 : rx_wr_q + 4'h1;
        end
        if (rd_data && rx_cnt_q != 4'h0) begin
          rx_rd_q <= rx_rd_q == 4'he ? 4'h0 : rx_rd_q + 4'h1;
        end
        rx_cnt_q <= rx_cnt_q + 4'((rx_push && rx_cnt_q != uart_fifo_pkg::FIFO_FULL_COUNT))
                    - 4'((rd_data && rx_cnt_q != 4'h0));
      end
    end
  end

  // transmitter
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_st_q <= uart_fifo_pkg::TX_IDLE;
      tx_sh_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      txd_q <= 1'b1;
    end else if (I_CE) begin
      case (tx_st_q)
        uart_fifo_pkg::TX_IDLE: begin
          txd_q <= !cfg_q.break_ctrl;
          if (tx_pop) begin
            tx_sh_q <= tx_mem_q[tx_rd_q];
            tx_par_q <= parity_of(tx_mem_q[tx_rd_q], nbits, cfg_q);
            tx_bit_q <= 3'h0;
            txd_q <= 1'b0;
            tx_st_q <= uart_fifo_pkg::TX_START;
          end
        end
        uart_fifo_pkg::TX_START: begin
          if (tx_tick) begin
            txd_q <= tx_sh_q[0] && !cfg_q.break_ctrl;
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_st_q <= uart_fifo_pkg::TX_DATA;
          end
        end
        uart_fifo_pkg::TX_DATA: begin
          if (tx_tick) begin
            if ({1'b0, tx_bit_q} == nbits - 4'h1) begin
              tx_stop2_q <= cfg_q.two_stop_select;
              if (cfg_q.parity_enable) begin
                txd_q <= tx_par_q && !cfg_q.break_ctrl;
                tx_st_q <= uart_fifo_pkg::TX_PAR;
              end else begin
                txd_q <= !cfg_q.break_ctrl;
                tx_st_q <= uart_fifo_pkg::TX_STOP;
              end
            end else begin
              txd_q <= tx_sh_q[0] && !cfg_q.break_ctrl;
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        uart_fifo_pkg::TX_PAR: begin
          if (tx_tick) begin
            txd_q <= !cfg_q.break_ctrl;
            tx_st_q <= uart_fifo_pkg::TX_STOP;
          end
        end
        default: begin
          if (tx_tick) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_st_q <= uart_fifo_pkg::TX_IDLE;
            end
          end
        end
      endcase
      if (cfg_q.break_ctrl) begin
        txd_q <= 1'b0;
      end
    end
  end

  // receiver; samples mid-bit, line taken as synchronous
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_st_q <= uart_fifo_pkg::RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_par_q <= 1'b0;
      rx_parity_error_flag_q <= 1'b0;
    end else if (I_CE) begin
      case (rx_st_q)
        uart_fifo_pkg::RX_IDLE: begin
          if (cfg_q.serial_enable && !I_RXD && baud_q != 16'h0000) begin
            rx_st_q <= uart_fifo_pkg::RX_START;
          end
        end
        uart_fifo_pkg::RX_START: begin
          if (rx_half) begin
            rx_st_q <= I_RXD ? uart_fifo_pkg::RX_IDLE : uart_fifo_pkg::RX_DATA;
            rx_bit_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_sh_q <= 8'h00;
          end
        end
        uart_fifo_pkg::RX_DATA: begin
          if (rx_half) begin
            rx_sh_q[rx_bit_q] <= I_RXD;
            rx_par_q <= rx_par_q ^ I_RXD;
            rx_bit_q <= rx_bit_q + 3'h1;
            if ({1'b0, rx_bit_q} == nbits - 4'h1) begin
              rx_st_q <= cfg_q.parity_enable ? uart_fifo_pkg::RX_PAR : uart_fifo_pkg::RX_STOP;
            end
          end
        end
        uart_fifo_pkg::RX_PAR: begin
          if (rx_half) begin
            rx_parity_error_flag_q <= cfg_q.stick_parity_one ? !I_RXD
                         : (rx_par_q ^ cfg_q.odd_parity_select) != I_RXD;
            rx_st_q <= uart_fifo_pkg::RX_STOP;
          end
        end
        default: begin
          if (rx_half) begin
            rx_st_q <= uart_fifo_pkg::RX_IDLE;
            if (!cfg_q.parity_enable) begin
              rx_parity_error_flag_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end
  assign rx_push = I_CE && rx_st_q == uart_fifo_pkg::RX_STOP && rx_half;
  assign rx_framing_error_flag = rx_push && !I_RXD;

  // idle timer counts clocks since the last byte left the line
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      idle_q <= 24'h000000;
    end else if (I_CE) begin
      if (rx_st_q != uart_fifo_pkg::RX_IDLE || rx_cnt_q == 4'h0) begin
        idle_q <= 24'h000000;
      end else if (idle_q <= idle_lim) begin
        idle_q <= idle_q + 24'h000001;
      end
    end
  end

  // status flags: hardware set beats a same-cycle software clear
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      flag_q <= 7'h00;
    end else if (I_CE) begin
      flag_q[uart_fifo_pkg::FLAG_TX_READY] <= tx_cnt_q < tx_thr_q;
      if (rx_cnt_q > rx_thr_q ||
          // one-shot on reaching the limit, so a zero write can still clear it
          (rx_cnt_q != 4'h0 && rx_cnt_q < rx_thr_q && idle_q == idle_lim)) begin
        flag_q[uart_fifo_pkg::FLAG_RX_AVAIL] <= 1'b1;
      end else if (req.wr && req.addr == uart_fifo_pkg::IRQ_FLAG_ENABLE_ADDR &&
                   !req.wdata[uart_fifo_pkg::FLAG_RX_AVAIL] && rx_cnt_q < rx_thr_q) begin
        flag_q[uart_fifo_pkg::FLAG_RX_AVAIL] <= 1'b0;
      end
      for (int i = 0; i < 5; i++) begin
        if (req.wr && req.addr == uart_fifo_pkg::IRQ_FLAG_ENABLE_ADDR && !req.wdata[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
      if (fifo_rst) begin
        flag_q[uart_fifo_pkg::FLAG_RX_OVF] <= 1'b0;
        flag_q[uart_fifo_pkg::FLAG_RX_UNF] <= 1'b0;
        flag_q[uart_fifo_pkg::FLAG_TX_OVF] <= 1'b0;
      end
      if (rx_push && rx_cnt_q == uart_fifo_pkg::FIFO_FULL_COUNT) begin
        flag_q[uart_fifo_pkg::FLAG_RX_OVF] <= 1'b1;
      end
      if (rd_data && rx_cnt_q == 4'h0) begin
        flag_q[uart_fifo_pkg::FLAG_RX_UNF] <= 1'b1;
      end
      if (wr_data && tx_cnt_q == uart_fifo_pkg::FIFO_FULL_COUNT) begin
        flag_q[uart_fifo_pkg::FLAG_TX_OVF] <= 1'b1;
      end
      if (rx_framing_error_flag) begin
        flag_q[uart_fifo_pkg::FLAG_FRAMING] <= 1'b1;
      end
      if (tx_busy && tx_st_q == uart_fifo_pkg::TX_STOP && tx_tick && !tx_stop2_q &&
          tx_cnt_q == 4'h0) begin
        flag_q[uart_fifo_pkg::FLAG_TX_DONE] <= 1'b1;
      end
    end
  end

  // read data and interrupt output
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else if (I_CE) begin
      irq_q <= irq_master_q && |(flag_q & irq_en_q);
      if (!req.rd) begin
        rdata_q <= 8'h00;
      end else if (req.addr == uart_fifo_pkg::SERIAL_LINE_CONFIG_ADDR) begin
        rdata_q <= {cfg_q[7:2], rx_mem_q[rx_rd_q][8] && rx_cnt_q != 4'h0,
                    cfg_q.stick_parity_one};
      end else if (req.addr == uart_fifo_pkg::FIFO_LEVEL_THRESHOLD_ADDR) begin
        rdata_q <= {rx_cnt_q, tx_cnt_q};
      end else if (req.addr == uart_fifo_pkg::IRQ_FLAG_ENABLE_ADDR) begin
        rdata_q <= {1'b0, flag_q};
      end else if (req.addr == uart_fifo_pkg::SERIAL_DATA_BUFFER_ADDR) begin
        rdata_q <= rx_cnt_q != 4'h0 ? rx_mem_q[rx_rd_q][7:0] : 8'h00;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign O_RDATA = rdata_q;
  assign O_TXD = txd_q;
  assign O_IRQ = irq_q;

  AST_BREAK_LOW: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CE && cfg_q.break_ctrl |=> !O_TXD)
    else $error("break did not hold line low");
  AST_TX_OVF: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    wr_data && tx_cnt_q == 4'hf && !fifo_rst |=> flag_q[uart_fifo_pkg::FLAG_TX_OVF])
    else $error("tx overflow not flagged");
  AST_RX_UNF: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    rd_data && rx_cnt_q == 4'h0 |=> flag_q[uart_fifo_pkg::FLAG_RX_UNF] && rx_cnt_q == 4'h0)
    else $error("rx underflow not flagged");
  AST_FIFO_RST: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CE && fifo_rst |=> tx_cnt_q == 4'h0 && rx_cnt_q == 4'h0)
    else $error("fifo reset left data");
  AST_TX_READY: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CE |=> flag_q[uart_fifo_pkg::FLAG_TX_READY] == ($past(tx_cnt_q) < $past(tx_thr_q)))
    else $error("tx ready wrong");
  AST_IRQ: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CE && !irq_master_q |=> !O_IRQ)
    else $error("irq without master enable");
  AST_RX_AVAIL: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CE && rx_cnt_q > rx_thr_q |=> flag_q[uart_fifo_pkg::FLAG_RX_AVAIL])
    else $error("rx avail not set");
  AST_STATUS: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CE && req.rd && req.addr == 8'ha5 |=> O_RDATA == {$past(rx_cnt_q), $past(tx_cnt_q)})
    else $error("fifo status read wrong");
endmodule
`default_nettype wire

/* File: verification/serial_peer.sv */
// remote serial device model that sends frames and captures frames
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int DIV = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int nbits = 10;
  int nframes = 0;
  logic [11:0] last_frame = 12'h000;
  // idle level is high between frames
  initial line_out = 1'b1;
  // low start, then the given bits lsb first, then back to idle
  task automatic send(input logic [11:0] f, input int n);
    @(posedge clk);
    line_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (DIV) @(posedge clk);
      line_out <= f[i];
    end
    repeat (DIV) @(posedge clk);
    line_out <= 1'b1;
    repeat (DIV) @(posedge clk);
  endtask
  // mid-bit sampling, so a wrong bit period drifts out of the window
  always begin
    logic [11:0] f;
    @(negedge line_in);
    f = 12'h000;
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (DIV) @(posedge clk);
      f[i] = line_in;
    end
    last_frame = f;
    nframes++;
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the fifo serial transceiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DIV = 16;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic irq;
  int fail_count = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  uart_fifo_core uart_fifo_core_i (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RXD(rxd), .O_TXD(txd),
    .O_IRQ(irq));
  serial_peer #(.DIV(DIV)) serial_peer_i (.clk(clk), .line_in(txd), .line_out(rxd));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string w);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(w, rdata & m, e);
  endtask
  // bits after the start bit for config c and data d; returns their count
  function automatic int mk(input logic [7:0] c, input logic [7:0] d, output logic [11:0] f);
    int n;
    logic p;
    n = 5 + int'(c[5:4]);
    f = 12'h000;
    p = 1'b0;
    for (int i = 0; i < n; i++) begin
      f[i] = d[i];
      p = p ^ d[i];
    end
    if (c[1]) begin
      f[n] = c[0] ? 1'b1 : (p ^ c[2]);
      n++;
    end
    f[n] = 1'b1;
    f[n + 1] = c[6];
    return n + 1 + int'(c[6]);
  endfunction
  task automatic t_reset();
    rchk(8'ha5, 8'hff, 8'h00, "fifo status");
    rchk(8'ha7, 8'hff, 8'h00, "irq reg");
    rchk(8'hc2, 8'hff, 8'h00, "line cfg");
    rchk(8'h10, 8'hff, 8'h00, "unmapped");
    chk("txd idle", {7'h00, txd}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_tx();
    logic [7:0] cfgs [5] = '{8'hb0, 8'hc0, 8'ha2, 8'h96, 8'hb3};
    logic [7:0] dats [5] = '{8'h96, 8'h1b, 8'h4d, 8'h2e, 8'h03};
    logic [11:0] f;
    int n0;
    for (int k = 0; k < 5; k++) begin
      serial_peer_i.nbits = mk(cfgs[k], dats[k], f);
      wreg(8'hc2, cfgs[k]);
      n0 = serial_peer_i.nframes;
      wreg(8'ha6, dats[k]);
      for (int t = 0; t < 400 && serial_peer_i.nframes == n0; t++) @(posedge clk);
      chk("frame seen", 8'(serial_peer_i.nframes - n0), 8'h01);
      chk("frame low", serial_peer_i.last_frame[7:0], f[7:0]);
      chk("frame high", {4'h0, serial_peer_i.last_frame[11:8]}, {4'h0, f[11:8]});
      repeat (3 * DIV) @(posedge clk);
      rchk(8'ha7, 8'h01, 8'h01, "tx done");
      wreg(8'ha7, 8'h00);
    end
    rchk(8'ha7, 8'h01, 8'h00, "tx done cleared");
    $display("test tx done");
  endtask
  task automatic t_break();
    int lows;
    lows = 0;
    wreg(8'hc2, 8'h88);
    repeat (4) @(posedge clk);
    for (int t = 0; t < 20 * DIV; t++) begin
      @(posedge clk);
      lows += int'(txd === 1'b0);
    end
    chk("break low", 8'(lows / DIV), 8'h14);
    wreg(8'hc2, 8'h80);
    repeat (3 * DIV) @(posedge clk);
    chk("break over", {7'h00, txd}, 8'h01);
    $display("test break done");
  endtask
  task automatic t_rx();
    logic [11:0] f;
    int n;
    wreg(8'hc2, 8'hb2);
    wreg(8'ha5, 8'h01);
    n = mk(8'hb2, 8'ha5, f);
    serial_peer_i.send(f, n);
    rchk(8'ha5, 8'hff, 8'h10, "rx count");
    rchk(8'ha7, 8'h60, 8'h60, "rx avail tx ready");
    rchk(8'hc2, 8'h02, 8'h00, "parity ok");
    rchk(8'ha6, 8'hff, 8'ha5, "rx data");
    n = mk(8'hb2, 8'h3c, f);
    f[8] = ~f[8];
    serial_peer_i.send(f, n);
    rchk(8'hc2, 8'h02, 8'h02, "parity error");
    rchk(8'ha6, 8'hff, 8'h3c, "rx data bad parity");
    n = mk(8'hb2, 8'h77, f);
    f[9] = 1'b0;
    serial_peer_i.send(f, n);
    rchk(8'ha7, 8'h02, 8'h02, "framing");
    wreg(8'ha7, 8'h00);
    rchk(8'ha7, 8'h02, 8'h00, "framing cleared");
    $display("test rx done");
  endtask
  task automatic t_ovf();
    logic [11:0] f;
    int n;
    int n0;
    wreg(8'hc2, 8'hb0);
    n = mk(8'hb0, 8'h00, f);
    for (int k = 0; k < 16; k++) serial_peer_i.send(f, n);
    rchk(8'ha5, 8'hf0, 8'hf0, "rx full");
    rchk(8'ha7, 8'h10, 8'h10, "rx overflow");
    wreg(8'hc2, 8'h30);
    n0 = serial_peer_i.nframes;
    for (int k = 0; k < 16; k++) wreg(8'ha6, 8'(k));
    rchk(8'ha5, 8'h0f, 8'h0f, "tx full");
    rchk(8'ha7, 8'h44, 8'h04, "tx overflow not ready");
    chk("no tx while off", 8'(serial_peer_i.nframes - n0), 8'h00);
    wreg(8'ha4, 8'h00);
    rchk(8'ha5, 8'hff, 8'h00, "fifo reset");
    rchk(8'ha7, 8'h5c, 8'h40, "flags reset");
    wreg(8'ha4, 8'(DIV));
    serial_peer_i.send(f, n);
    rchk(8'ha5, 8'hf0, 8'h00, "no rx while off");
    $display("test overflow done");
  endtask
  task automatic t_irq();
    rchk(8'ha6, 8'hff, 8'h00, "empty read");
    rchk(8'ha7, 8'h08, 8'h08, "rx underflow");
    wreg(8'ha7, 8'h88);
    repeat (3) @(posedge clk);
    chk("irq on", {7'h00, irq}, 8'h01);
    wreg(8'ha7, 8'h08);
    repeat (3) @(posedge clk);
    chk("irq master off", {7'h00, irq}, 8'h00);
    wreg(8'ha7, 8'h80);
    rchk(8'ha7, 8'h08, 8'h00, "underflow cleared");
    chk("irq flag off", {7'h00, irq}, 8'h00);
    $display("test irq done");
  endtask
  // one byte below a threshold of two, then a long quiet line
  task automatic t_idle();
    logic [11:0] f;
    int n;
    wreg(8'hc2, 8'hb0);
    wreg(8'ha5, 8'h21);
    wreg(8'ha7, 8'h00);
    n = mk(8'hb0, 8'h5a, f);
    serial_peer_i.send(f, n);
    rchk(8'ha7, 8'h20, 8'h00, "rx avail below thr");
    repeat (40 * DIV) @(posedge clk);
    rchk(8'ha7, 8'h20, 8'h20, "rx idle timeout");
    wreg(8'ha7, 8'h00);
    rchk(8'ha7, 8'h20, 8'h00, "rx avail cleared");
    $display("test idle done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    wreg(8'ha3, 8'h00);
    wreg(8'ha4, 8'(DIV));
    t_tx();
    t_break();
    t_rx();
    t_ovf();
    t_irq();
    t_idle();
    stop_test();
  end
  // the whole run needs well under a fifth of this span
  initial begin
    #(60000 * 8);
    fail_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
